// ---- verilog/gateway_defs.svh ----
`ifndef GATEWAY_DEFS_SVH
`define GATEWAY_DEFS_SVH

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK 12'h008
`define OFS_CFG 12'h00C
`define OFS_TABLE 12'h800

`define STAT_OWNED 0
`define STAT_ACQ_TO 1
`define STAT_XFER_TO 2
`define STAT_GRANTED 3

`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00
`define CFG_RESET 11'h000

`define MB_LOW 4'h0
`define MB_HIGH 4'hF

`define CLK_PERIOD_PS 25000
`define US_PS 1000000
`define US_CYCLES (`US_PS / `CLK_PERIOD_PS)
`define ACQ_TIMEOUT_US 128
`define XFER_TIMEOUT_US 8
`endif

// ---- verilog/gateway_pkg.sv ----
package gateway_pkg;
  typedef enum logic [2:0] {
    TGT_BUS = 3'h0,
    TGT_PAIR0 = 3'h1,
    TGT_PAIR1 = 3'h2,
    TGT_PAIR2 = 3'h3,
    TGT_PAIR3 = 3'h4,
    TGT_IO = 3'h5
  } target_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOCAL = 5'h02,
    ST_ACQ = 5'h04,
    ST_XFER = 5'h08,
    ST_DONE = 5'h10
  } state_t;

  typedef struct packed {
    logic [2:0] display;
    logic sysfail;
    logic xfer_to_en;
    logic acq_to_en;
    logic auto_mode;
    logic req_cmd;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] pair_rom;
    logic [3:0] rom_wait;
    logic sys_ctrl;
    logic [1:0] level;
  } cfg_t;

  typedef struct packed {
    logic [23:0] addr;
    logic we;
    logic [1:0] be;
    logic [15:0] wdata;
  } cpu_cmd_t;

  typedef struct packed {
    logic dtack_n;
    logic berr_n;
    logic bbsy_n;
    logic br3_n;
    logic [3:0] bg_in_n;
    logic [15:0] d;
  } pins_t;

  typedef struct packed {
    logic [7:0] count;
    logic [5:0] presc;
    logic expired;
  } to_state_t;

  typedef struct packed {
    state_t state;
    cpu_cmd_t cmd;
    logic [3:0] wait_cnt;
    ctrl_t ctrl;
    cfg_t cfg;
    logic [7:0] mask;
    logic [3:1] sticky;
    logic owned;
    logic breq;
    logic auto_hold;
    logic arb_bg_n;
    logic cpu_ack;
    logic cpu_berr;
    logic [15:0] cpu_rdata;
    logic as_n;
    logic [1:0] ds_n;
    logic write_n;
    logic d_oe;
    logic [3:0] br_oe;
    logic [3:0] bg_out_n;
    logic [3:0] loc_cs_n;
    logic io_cs_n;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    pins_t pin1;
    pins_t pin2;
    target_t [511:0] map;
  } gw_state_t;
endpackage : gateway_pkg

// ---- verilog/timeout_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gateway_defs.svh"

module timeout_counter #(
  parameter int unsigned LIMIT_US = `XFER_TIMEOUT_US
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic enable,
  input wire logic start,
  input wire logic run,
  // Result
  output logic expired
);
  gateway_pkg::to_state_t s_reg;
  gateway_pkg::to_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.expired = 1'b0;
    if (srst || start || !run) begin
      s_next = '0;
    end else if (enable && !s_reg.expired) begin
      if (s_reg.presc == 6'(`US_CYCLES - 1)) begin
        s_next.presc = 6'h00;
        s_next.count = s_reg.count + 8'h01;
        if (s_reg.count == 8'(LIMIT_US - 1)) begin
          s_next.expired = 1'b1;
        end
      end else begin
        s_next.presc = s_reg.presc + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign expired = s_reg.expired;
endmodule : timeout_counter
`default_nettype wire

// ---- verilog/local_to_backplane_bus_gateway.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gateway_defs.svh"

module local_to_backplane_bus_gateway #(
  parameter int unsigned ACQ_TIMEOUT_US = `ACQ_TIMEOUT_US
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic [11:0] av_address,
  input wire logic av_read,
  input wire logic av_write,
  input wire logic [31:0] av_writedata,
  input wire logic [3:0] av_byteenable,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  output logic irq,
  // Processor side
  input wire logic cpu_req,
  input wire gateway_pkg::cpu_cmd_t cpu_cmd,
  output logic cpu_ready,
  output logic cpu_ack,
  output logic cpu_berr,
  output logic [15:0] cpu_rdata,
  // Local memory and peripherals
  output gateway_pkg::cpu_cmd_t loc_cmd,
  output logic [3:0] loc_cs_n,
  output logic loc_io_cs_n,
  input wire logic [15:0] loc_rdata,
  // Backplane transfer
  output logic [23:0] vme_addr,
  output logic vme_as_n,
  output logic [1:0] vme_ds_n,
  output logic vme_write_n,
  output logic [15:0] vme_d_out,
  output logic vme_d_oe,
  input wire logic [15:0] vme_d_in,
  input wire logic vme_dtack_n,
  input wire logic vme_berr_n,
  // Backplane arbitration
  output logic [3:0] vme_br_oe,
  input wire logic [3:0] vme_bg_in_n,
  output logic [3:0] vme_bg_out_n,
  input wire logic vme_bbsy_in_n,
  output logic vme_bbsy_oe,
  input wire logic vme_br3_in_n,
  output logic vme_arb_bg_n,
  // Front panel and system
  output logic vme_sysfail_oe,
  output logic [2:0] display
);
  gateway_pkg::gw_state_t s_reg;
  gateway_pkg::gw_state_t s_next;

  logic seg_hit;
  logic [8:0] seg_idx;
  gateway_pkg::target_t tgt;
  logic [3:0] pair_sel;
  logic [3:0] br_sel;
  logic [3:0] bg_pass;
  logic acq_start;
  logic acq_exp;
  logic xfer_start;
  logic xfer_exp;
  logic in_acq;
  logic in_xfer;

  // Segment decode of the incoming processor address
  assign seg_hit = (cpu_cmd.addr[23:20] == `MB_LOW) || (cpu_cmd.addr[23:20] == `MB_HIGH);
  assign seg_idx = {cpu_cmd.addr[23], cpu_cmd.addr[19:12]};
  assign tgt = seg_hit ? s_reg.map[seg_idx] : gateway_pkg::TGT_BUS;

  // Per-pair chip select and per-level request and grant chain
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign pair_sel[i] = (tgt == gateway_pkg::target_t'(3'(i + 1)));
    assign br_sel[i] = s_reg.breq && (s_reg.cfg.level == 2'(i));
    assign bg_pass[i] = br_sel[i] ? 1'b1 : s_reg.pin2.bg_in_n[i];
  end

  assign in_acq = (s_reg.state == gateway_pkg::ST_ACQ);
  assign in_xfer = (s_reg.state == gateway_pkg::ST_XFER);
  assign acq_start = (s_reg.state == gateway_pkg::ST_IDLE);
  assign xfer_start = !in_xfer;

  timeout_counter #(
    .LIMIT_US(ACQ_TIMEOUT_US)
  ) u_acq_to (
    .clk(clk),
    .srst(srst),
    .enable(s_reg.ctrl.acq_to_en),
    .start(acq_start),
    .run(in_acq),
    .expired(acq_exp)
  );

  timeout_counter #(
    .LIMIT_US(`XFER_TIMEOUT_US)
  ) u_xfer_to (
    .clk(clk),
    .srst(srst),
    .enable(s_reg.ctrl.xfer_to_en),
    .start(xfer_start),
    .run(in_xfer),
    .expired(xfer_exp)
  );

  always_comb begin
    logic want;
    logic bg_mine;
    logic take;
    logic [3:1] ev;
    logic [7:0] status;
    logic [3:1] cleared;
    want = 1'b0;
    bg_mine = 1'b0;
    take = 1'b0;
    ev = 3'h0;
    status = 8'h00;
    cleared = 3'h0;

    s_next = s_reg;
    s_next.cpu_ack = 1'b0;
    s_next.cpu_berr = 1'b0;
    s_next.pin1 = {vme_dtack_n, vme_berr_n, vme_bbsy_in_n, vme_br3_in_n, vme_bg_in_n, vme_d_in};
    s_next.pin2 = s_reg.pin1;

    // Register bus: one wait cycle, then the access takes effect
    take = (av_read || av_write) && !s_reg.waitreq;
    s_next.waitreq = !((av_read || av_write) && s_reg.waitreq);
    status = {4'h0, s_reg.sticky, s_reg.owned};
    if ((av_read || av_write) && s_reg.waitreq) begin
      s_next.rdata = 32'h0000_0000;
      if (av_read) begin
        if (av_address >= `OFS_TABLE) begin
          s_next.rdata = {29'h0, s_reg.map[av_address[10:2]]};
        end else begin
          unique case (av_address)
            `OFS_CTRL: s_next.rdata = {24'h0, s_reg.ctrl};
            `OFS_STATUS: s_next.rdata = {24'h0, status};
            `OFS_MASK: s_next.rdata = {24'h0, s_reg.mask};
            `OFS_CFG: s_next.rdata = {21'h0, s_reg.cfg};
            default: s_next.rdata = 32'h0000_0000;
          endcase
        end
      end
    end
    if (take && av_read && (av_address == `OFS_STATUS)) begin
      cleared = s_reg.rdata[3:1];
    end
    if (take && av_write && av_byteenable[0]) begin
      if (av_address >= `OFS_TABLE) begin
        s_next.map[av_address[10:2]] = gateway_pkg::target_t'(av_writedata[2:0]);
      end else begin
        unique case (av_address)
          `OFS_CTRL: s_next.ctrl = av_writedata[7:0];
          `OFS_MASK: s_next.mask = av_writedata[7:0];
          `OFS_CFG: s_next.cfg[7:0] = av_writedata[7:0];
          default: s_next.mask = s_reg.mask;
        endcase
      end
    end
    if (take && av_write && av_byteenable[1] && (av_address == `OFS_CFG)) begin
      s_next.cfg[10:8] = av_writedata[10:8];
    end

    // Requester
    // An off-board cycle always asks for the bus; auto mode only keeps it afterwards
    want = s_reg.ctrl.req_cmd || in_acq || in_xfer || (s_reg.ctrl.auto_mode && s_reg.auto_hold);
    bg_mine = !s_reg.pin2.bg_in_n[s_reg.cfg.level];
    if (!s_reg.owned) begin
      s_next.breq = want;
      if (s_reg.breq && bg_mine && s_reg.pin2.bbsy_n) begin
        s_next.owned = 1'b1;
        s_next.breq = 1'b0;
        ev[`STAT_GRANTED] = 1'b1;
      end
    end else if (!want && (s_reg.state == gateway_pkg::ST_IDLE || s_reg.state == gateway_pkg::ST_LOCAL)) begin
      s_next.owned = 1'b0;
    end

    // Single-level arbiter on the level-3 request line
    if (!s_reg.cfg.sys_ctrl) begin
      s_next.arb_bg_n = 1'b1;
    end else if (s_reg.arb_bg_n && !s_reg.pin2.br3_n && s_reg.pin2.bbsy_n) begin
      s_next.arb_bg_n = 1'b0;
    end else if (!s_reg.arb_bg_n && (!s_reg.pin2.bbsy_n || s_reg.pin2.br3_n)) begin
      s_next.arb_bg_n = 1'b1;
    end

    // Processor cycle
    unique case (s_reg.state)
      gateway_pkg::ST_IDLE: begin
        if (cpu_req) begin
          s_next.cmd = cpu_cmd;
          if (tgt == gateway_pkg::TGT_BUS) begin
            s_next.auto_hold = 1'b1;
            s_next.state = gateway_pkg::ST_ACQ;
          end else begin
            s_next.auto_hold = 1'b0;
            s_next.wait_cnt = |(pair_sel & s_reg.cfg.pair_rom) ? s_reg.cfg.rom_wait : 4'h0;
            s_next.loc_cs_n = ~pair_sel;
            s_next.io_cs_n = (tgt != gateway_pkg::TGT_IO);
            s_next.state = gateway_pkg::ST_LOCAL;
          end
        end
      end
      gateway_pkg::ST_LOCAL: begin
        if (s_reg.wait_cnt == 4'h0) begin
          s_next.cpu_ack = 1'b1;
          s_next.cpu_rdata = loc_rdata;
          s_next.loc_cs_n = 4'hF;
          s_next.io_cs_n = 1'b1;
          s_next.state = gateway_pkg::ST_IDLE;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
        end
      end
      gateway_pkg::ST_ACQ: begin
        if (acq_exp) begin
          s_next.cpu_berr = 1'b1;
          s_next.breq = 1'b0;
          s_next.auto_hold = 1'b0;
          ev[`STAT_ACQ_TO] = 1'b1;
          s_next.state = gateway_pkg::ST_IDLE;
        end else if (s_reg.owned) begin
          s_next.as_n = 1'b0;
          s_next.ds_n = ~s_reg.cmd.be;
          s_next.write_n = !s_reg.cmd.we;
          s_next.d_oe = s_reg.cmd.we;
          s_next.state = gateway_pkg::ST_XFER;
        end
      end
      gateway_pkg::ST_XFER: begin
        if (!s_reg.pin2.dtack_n || !s_reg.pin2.berr_n || xfer_exp) begin
          s_next.cpu_ack = !s_reg.pin2.dtack_n;
          s_next.cpu_berr = s_reg.pin2.dtack_n;
          s_next.cpu_rdata = s_reg.pin2.d;
          ev[`STAT_XFER_TO] = s_reg.pin2.dtack_n && s_reg.pin2.berr_n;
          s_next.as_n = 1'b1;
          s_next.ds_n = 2'h3;
          s_next.d_oe = 1'b0;
          s_next.state = gateway_pkg::ST_DONE;
        end
      end
      gateway_pkg::ST_DONE: begin
        if (s_reg.pin2.dtack_n && s_reg.pin2.berr_n) begin
          s_next.write_n = 1'b1;
          s_next.state = gateway_pkg::ST_IDLE;
        end
      end
      default: s_next.state = gateway_pkg::ST_IDLE;
    endcase

    // Sticky flags: a new event wins over a read clear
    s_next.sticky = (s_reg.sticky & ~cleared) | ev;
    s_next.br_oe = br_sel;
    s_next.bg_out_n = bg_pass;
    s_next.irq = |({s_next.sticky, 1'b0} & s_reg.mask[3:0]);

    if (srst) begin
      s_next = '0;
      s_next.state = gateway_pkg::ST_IDLE;
      s_next.ctrl = `CTRL_RESET;
      s_next.mask = `MASK_RESET;
      s_next.cfg = `CFG_RESET;
      s_next.arb_bg_n = 1'b1;
      s_next.as_n = 1'b1;
      s_next.ds_n = 2'h3;
      s_next.write_n = 1'b1;
      s_next.bg_out_n = 4'hF;
      s_next.loc_cs_n = 4'hF;
      s_next.io_cs_n = 1'b1;
      s_next.waitreq = 1'b1;
      s_next.pin1 = '1;
      s_next.pin2 = '1;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign av_readdata = s_reg.rdata;
  assign av_waitrequest = s_reg.waitreq;
  assign irq = s_reg.irq;
  assign cpu_ready = s_reg.state[0];
  assign cpu_ack = s_reg.cpu_ack;
  assign cpu_berr = s_reg.cpu_berr;
  assign cpu_rdata = s_reg.cpu_rdata;
  assign loc_cmd = s_reg.cmd;
  assign loc_cs_n = s_reg.loc_cs_n;
  assign loc_io_cs_n = s_reg.io_cs_n;
  assign vme_addr = s_reg.cmd.addr;
  assign vme_as_n = s_reg.as_n;
  assign vme_ds_n = s_reg.ds_n;
  assign vme_write_n = s_reg.write_n;
  assign vme_d_out = s_reg.cmd.wdata;
  assign vme_d_oe = s_reg.d_oe;
  assign vme_br_oe = s_reg.br_oe;
  assign vme_bg_out_n = s_reg.bg_out_n;
  assign vme_bbsy_oe = s_reg.owned;
  assign vme_arb_bg_n = s_reg.arb_bg_n;
  assign vme_sysfail_oe = s_reg.ctrl.sysfail;
  assign display = s_reg.ctrl.display;
endmodule : local_to_backplane_bus_gateway
`default_nettype wire

// ---- dv/gateway_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module gateway_checker #(
  parameter int unsigned ACQ_TIMEOUT_US = 128
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched ports
  input wire logic av_read,
  input wire logic av_write,
  input wire logic av_waitrequest,
  input wire logic cpu_req,
  input wire gateway_pkg::cpu_cmd_t cpu_cmd,
  input wire logic cpu_ready,
  input wire logic cpu_ack,
  input wire logic cpu_berr,
  input wire logic [3:0] loc_cs_n,
  input wire logic loc_io_cs_n,
  input wire logic vme_as_n,
  input wire logic [3:0] vme_br_oe,
  input wire logic vme_bbsy_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic off_req;
  assign off_req = cpu_req && cpu_ready && cpu_cmd.addr >= 24'h100000 && cpu_cmd.addr <= 24'hEFFFFF;
  one_answer_a: assert property (!(cpu_ack && cpu_berr)) else $error("ack with bus error");
  take_busy_a: assert property (cpu_req && cpu_ready |=> !cpu_ready) else $error("request not taken");
  off_board_a: assert property (off_req |=> (loc_cs_n == 4'hF && loc_io_cs_n)[*3])
    else $error("local select on off-board access");
  local_quiet_a: assert property ((loc_cs_n != 4'hF || !loc_io_cs_n) |-> vme_as_n && vme_br_oe == 4'h0)
    else $error("backplane busy on local cycle");
  strobe_owned_a: assert property (!vme_as_n |-> vme_bbsy_oe) else $error("strobe without ownership");
  one_level_a: assert property ($onehot0(vme_br_oe)) else $error("several request levels");
  local_done_a: assert property (loc_cs_n != 4'hF |-> ##[1:17] cpu_ack) else $error("local cycle hangs");
  berr_release_a: assert property (cpu_berr |-> vme_as_n) else $error("strobe kept on bus error");
  bus_wait_a: assert property ($rose(av_read || av_write) |=> !av_waitrequest ##1 av_waitrequest)
    else $error("register access timing");
endmodule : gateway_checker
bind local_to_backplane_bus_gateway gateway_checker #(.ACQ_TIMEOUT_US(ACQ_TIMEOUT_US)) i_checker (
  .clk(clk), .srst(srst), .av_read(av_read), .av_write(av_write), .av_waitrequest(av_waitrequest),
  .cpu_req(cpu_req), .cpu_cmd(cpu_cmd), .cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .cpu_berr(cpu_berr),
  .loc_cs_n(loc_cs_n), .loc_io_cs_n(loc_io_cs_n), .vme_as_n(vme_as_n), .vme_br_oe(vme_br_oe),
  .vme_bbsy_oe(vme_bbsy_oe)
);
`default_nettype wire

// ---- dv/backplane_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Gateway side
  input wire logic [23:0] vme_addr,
  input wire logic vme_as_n,
  input wire logic vme_write_n,
  input wire logic [15:0] vme_d_out,
  input wire logic [3:0] vme_br_oe,
  // Bench controls
  input wire logic no_grant,
  input wire logic [15:0] ack_delay,
  // Answers
  output logic [3:0] vme_bg_in_n,
  output logic vme_dtack_n,
  output logic [15:0] vme_d_in,
  output logic [15:0] wr_last
);
  logic [15:0] cnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      vme_bg_in_n <= 4'hF;
      vme_dtack_n <= 1'b1;
      vme_d_in <= 16'h0000;
      wr_last <= 16'h0000;
      cnt <= 16'h0000;
    end else begin
      // Grant only on the level being requested
      vme_bg_in_n <= no_grant ? 4'hF : ~vme_br_oe;
      if (vme_as_n) begin
        cnt <= 16'h0000;
        vme_dtack_n <= 1'b1;
        vme_d_in <= ~vme_d_in;
      end else if (cnt >= ack_delay) begin
        vme_dtack_n <= 1'b0;
        vme_d_in <= vme_addr[15:0] ^ 16'hA5A5;
        if (!vme_write_n) wr_last <= vme_d_out;
      end else begin
        cnt <= cnt + 16'h0001;
        vme_d_in <= ~vme_d_in;
      end
    end
  end
endmodule : backplane_model
`default_nettype wire

// ---- dv/local_to_backplane_bus_gateway_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gateway_defs.svh"
module local_to_backplane_bus_gateway_tb_top;
  logic clk = 1'b0, srst = 1'b1, av_read = 1'b0, av_write = 1'b0, cpu_req = 1'b0, no_grant = 1'b0;
  logic [11:0] av_address = 12'h000;
  logic [31:0] av_writedata = 32'h0, av_readdata, q;
  logic [3:0] av_byteenable = 4'hF, loc_cs_n, vme_br_oe, vme_bg_in_n, vme_bg_out_n, got_br;
  logic [15:0] loc_rdata = 16'h0, ack_delay = 16'h0002, cpu_rdata, vme_d_out, vme_d_in, wr_last, got_rd;
  gateway_pkg::cpu_cmd_t cpu_cmd = '0, loc_cmd;
  logic av_waitrequest, irq, cpu_ready, cpu_ack, cpu_berr, loc_io_cs_n, vme_as_n, vme_write_n, got_ack;
  logic vme_d_oe, vme_dtack_n, vme_bbsy_oe, vme_arb_bg_n, vme_sysfail_oe;
  logic [1:0] vme_ds_n;
  logic [2:0] display;
  logic [4:0] got_cs;
  logic [23:0] vme_addr;
  int failures = 0, n_tests = 0, lat;
  // Only this board sits on the busy line
  wire logic vme_bbsy_in_n = ~vme_bbsy_oe;

  local_to_backplane_bus_gateway #(.ACQ_TIMEOUT_US(2)) i_dut (
    .clk, .srst, .av_address, .av_read, .av_write, .av_writedata, .av_byteenable, .av_readdata,
    .av_waitrequest, .irq, .cpu_req, .cpu_cmd, .cpu_ready, .cpu_ack, .cpu_berr, .cpu_rdata, .loc_cmd,
    .loc_cs_n, .loc_io_cs_n, .loc_rdata, .vme_addr, .vme_as_n, .vme_ds_n, .vme_write_n, .vme_d_out,
    .vme_d_oe, .vme_d_in, .vme_dtack_n, .vme_berr_n(1'b1), .vme_br_oe, .vme_bg_in_n, .vme_bg_out_n,
    .vme_bbsy_in_n, .vme_bbsy_oe, .vme_br3_in_n(1'b1), .vme_arb_bg_n, .vme_sysfail_oe, .display
  );
  backplane_model i_bp (
    .clk, .srst, .vme_addr, .vme_as_n, .vme_write_n, .vme_d_out, .vme_br_oe, .no_grant, .ack_delay,
    .vme_bg_in_n, .vme_dtack_n, .vme_d_in, .wr_last
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic tmo();
    failures++;
    $display("mismatch at %0t: wait timed out", $time);
    end_of_test();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_for(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 100) begin
      @(posedge clk);
      i++;
    end
    if (i >= 100) tmo();
  endtask : wait_for

  task automatic av(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    av_address <= a;
    av_writedata <= d;
    av_read <= !wr;
    av_write <= wr;
    // Look between edges so the value seen is the one the next edge samples
    do begin
      @(posedge clk);
      @(negedge clk);
      i++;
    end while (av_waitrequest !== 1'b0 && i < 50);
    if (i >= 50) tmo();
    q = av_readdata;
    @(posedge clk);
    av_read <= 1'b0;
    av_write <= 1'b0;
    @(posedge clk);
  endtask : av

  task automatic cpu(input logic [23:0] a, input logic we);
    cpu_cmd <= gateway_pkg::cpu_cmd_t'({a, we, 2'h3, a[15:0] ^ 16'h0F0F});
    cpu_req <= 1'b1;
    @(posedge clk);
    cpu_req <= 1'b0;
    lat = 0;
    got_br = 4'h0;
    do begin
      @(negedge clk);
      lat++;
      got_br |= vme_br_oe;
      if (lat == 1) got_cs = {loc_io_cs_n, loc_cs_n};
    end while (cpu_ack !== 1'b1 && cpu_berr !== 1'b1 && lat < 2000);
    if (lat >= 2000) tmo();
    got_ack = cpu_ack;
    got_rd = cpu_rdata;
    @(posedge clk);
    wait_for(cpu_ready, 1'b1);
  endtask : cpu

  task automatic t_regs();
    av(0, `OFS_CTRL, 0);
    chk(q, `CTRL_RESET);
    av(0, `OFS_STATUS, 0);
    chk(q, 0);
    av(1, `OFS_CTRL, 32'hF0);
    repeat (2) @(posedge clk);
    chk({display, vme_sysfail_oe}, 4'hF);
    av_byteenable <= 4'h0;
    av(1, `OFS_CTRL, 32'h00);
    av_byteenable <= 4'hF;
    av(0, `OFS_CTRL, 0);
    chk(q, 32'hF0);
    av(1, 12'h010, 32'hFF);
    av(0, 12'h010, 0);
    chk(q, 0);
    av(1, `OFS_CTRL, 0);
  endtask : t_regs

  task automatic t_local();
    logic [23:0] a[4] = '{24'h000000, 24'h001000, 24'hF00000, 24'hFFF000};
    logic [2:0] code[4] = '{3'h1, 3'h2, 3'h5, 3'h4};
    logic [4:0] cs[4] = '{5'h1E, 5'h1D, 5'h0F, 5'h17};
    int wt[4] = '{2, 5, 0, 2};
    loc_rdata <= 16'h1234;
    // Pair 1 is ROM with three wait cycles
    av(1, `OFS_CFG, 32'h119);
    foreach (a[i]) begin
      av(1, `OFS_TABLE + {a[i][23], a[i][19:12], 2'b00}, {29'h0, code[i]});
      cpu(a[i], 1'b0);
      chk(got_cs, cs[i]);
      chk(got_rd, 16'h1234);
      if (wt[i] != 0) chk(lat, wt[i]);
    end
  endtask : t_local

  task automatic t_bus();
    logic [23:0] a[3] = '{24'h100000, 24'hEFFFFE, 24'h005000};
    av(1, `OFS_CTRL, 32'h0C);
    av(1, `OFS_MASK, 32'h08);
    foreach (a[i]) begin
      cpu(a[i], 1'b1);
      chk(got_ack, 1'b1);
      chk(wr_last, a[i][15:0] ^ 16'h0F0F);
      chk(got_br, 4'h2);
    end
    cpu(24'h300004, 1'b0);
    chk(got_rd, 16'hA5A1);
    chk(irq, 1'b1);
    av(0, `OFS_STATUS, 0);
    chk(q[3], 1'b1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    for (int l = 0; l < 4; l++) begin
      av(1, `OFS_CFG, l);
      cpu(24'h400000, 1'b0);
      chk(got_br, 4'h1 << l);
    end
  endtask : t_bus

  task automatic t_own();
    av(1, `OFS_CTRL, 32'h01);
    wait_for(vme_bbsy_oe, 1'b1);
    chk(vme_bbsy_oe, 1'b1);
    av(1, `OFS_CTRL, 32'h00);
    wait_for(vme_bbsy_oe, 1'b0);
    av(1, `OFS_CTRL, 32'h02);
    cpu(24'h200000, 1'b0);
    repeat (4) @(posedge clk);
    chk(vme_bbsy_oe, 1'b1);
    cpu(24'h000000, 1'b0);
    wait_for(vme_bbsy_oe, 1'b0);
    chk(vme_bbsy_oe, 1'b0);
  endtask : t_own

  task automatic t_timeouts();
    no_grant <= 1'b1;
    av(1, `OFS_CTRL, 32'h04);
    av(1, `OFS_MASK, 32'h02);
    repeat (2) begin
      cpu(24'h200000, 1'b0);
      chk(got_ack, 1'b0);
      chk(lat >= 80 && lat <= 90, 1'b1);
      chk(irq, 1'b1);
      av(0, `OFS_STATUS, 0);
      chk(q[1], 1'b1);
    end
    no_grant <= 1'b0;
    ack_delay <= 16'hFFFF;
    av(1, `OFS_CTRL, 32'h08);
    cpu(24'h200000, 1'b1);
    chk(got_ack, 1'b0);
    chk(lat >= 320 && lat <= 340, 1'b1);
    av(0, `OFS_STATUS, 0);
    chk(q[2], 1'b1);
    // Slow slave must be awaited once supervision is off
    ack_delay <= 16'h0190;
    av(1, `OFS_CTRL, 32'h00);
    cpu(24'h200000, 1'b1);
    chk(got_ack, 1'b1);
    chk(lat > 400, 1'b1);
  endtask : t_timeouts

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_local();
    t_bus();
    t_own();
    t_timeouts();
    end_of_test();
  end
endmodule : local_to_backplane_bus_gateway_tb_top
`default_nettype wire
